// File: shared/spsc_pkg.sv
package spsc_pkg;
   // Register byte addresses
   localparam logic [7:0] STATUS_OFS = 8'hE8;
   localparam logic [7:0] CAPS_OFS   = 8'hF8;
   localparam logic [7:0] REV_OFS    = 8'hFC;
   // Violation source field and code positions
   localparam int SRC_LSB  = 8;
   localparam int CODE_LSB = 0;
   // Reset values
   localparam logic [31:0] STATUS_RST = 32'h0000_0000;
   localparam logic [31:0] CAPS_VALUE = 32'h001F_0154;
   // Arbitrary revision value, no meaning
   localparam logic [11:0] REV_NUMBER = 12'h123;
   localparam logic [3:0]  REV_RSVD   = 4'h0;
   // Capability bit positions
   localparam int SPURIOUS_GUARD_POS = 20;
   localparam int RX_QUEUE_POS       = 19;
   localparam int BRIDGE_KIND_POS    = 18;
   localparam int SELECT_RELEASE_POS = 17;
   localparam int EXT_DECODER_POS    = 16;
   localparam int FIXED_LEN_LSB      = 9;
   localparam int LEN_ADJ_POS        = 8;
   localparam int PHASE_ZERO_POS     = 7;
   localparam int PHASE_ADJ_POS      = 6;
   localparam int POL_POS_POS        = 5;
   localparam int POL_ADJ_POS        = 4;
   localparam int SEL_COUNT_LSB      = 0;
   // AXI responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // Number of chip-select lines
   localparam int NUM_SELECTS = 4;
endpackage : spsc_pkg

// File: tb/testbench.sv
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic        aclk = 1'b0;
   logic        aresetn = 1'b0;
   logic        aclken = 1'b1;
   logic [7:0]  s_axi_awaddr = 8'h00;
   logic        s_axi_awvalid = 1'b0;
   logic        s_axi_awready;
   logic [31:0] s_axi_wdata = 32'h0000_0000;
   logic [3:0]  s_axi_wstrb = 4'hF;
   logic        s_axi_wvalid = 1'b0;
   logic        s_axi_wready;
   logic [1:0]  s_axi_bresp;
   logic        s_axi_bvalid;
   logic        s_axi_bready = 1'b0;
   logic [7:0]  s_axi_araddr = 8'h00;
   logic        s_axi_arvalid = 1'b0;
   logic        s_axi_arready;
   logic [31:0] s_axi_rdata;
   logic [1:0]  s_axi_rresp;
   logic        s_axi_rvalid;
   logic        s_axi_rready = 1'b0;
   logic        blocked_write = 1'b0;
   logic [7:0]  blocked_offset = 8'h00;
   logic        soft_reset_prot = 1'b0;
   logic        cfg_write = 1'b0;
   logic        active_sel_write = 1'b0;
   logic [7:0]  active_sel_offset = 8'h00;
   logic [2:0]  violation_status_code;
   logic [31:0] d;
   logic [7:0]  src;
   int          n_mismatch = 0;
   int          samples_checked = 0;

   spsc_regs DUT (
      .aclk(aclk), .aresetn(aresetn), .aclken(aclken),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready), .blocked_write(blocked_write),
      .blocked_offset(blocked_offset), .soft_reset_prot(soft_reset_prot),
      .cfg_write(cfg_write), .active_sel_write(active_sel_write),
      .active_sel_offset(active_sel_offset),
      .violation_status_code(violation_status_code)
   );

   always #10 aclk = ~aclk;

   task automatic results;
      if (n_mismatch == 0 && samples_checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : results

   task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                        input string msg);
      samples_checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: %s got %h exp %h", $time, msg,
                  seen, exp);
      end
   endtask : check

   task automatic rd(input logic [7:0] a, input logic [31:0] e,
                     input logic [1:0] re, output logic [31:0] v);
      logic       done;
      logic [1:0] r;
      done = 1'b0;
      v = 32'h0000_0000;
      r = 2'h3;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (int n = 0; n < 40 && !done; n++) begin
         @(posedge aclk);
         if (s_axi_arvalid && s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid === 1'b1) begin
            v = s_axi_rdata;
            r = s_axi_rresp;
            s_axi_rready <= 1'b0;
            done = 1'b1;
         end
      end
      check(32'(done), 32'h1, "read answer");
      check(32'(r), 32'(re), "read resp");
      check(v, e, "read data");
   endtask : rd

   task automatic wr(input logic [7:0] a, input logic [1:0] re);
      logic       done;
      logic [1:0] r;
      done = 1'b0;
      r = 2'h3;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= 32'hFFFF_FFFF;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (int n = 0; n < 40 && !done; n++) begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid === 1'b1) begin
            r = s_axi_bresp;
            s_axi_bready <= 1'b0;
            done = 1'b1;
         end
      end
      check(32'(done), 32'h1, "write answer");
      check(32'(r), 32'(re), "write resp");
   endtask : wr

   // Event pulse: mask bits are cfg, active select, soft reset, blocked
   task automatic ev(input logic [3:0] m, input logic [7:0] bo,
                     input logic [7:0] ao);
      @(posedge aclk);
      blocked_write <= m[0];
      soft_reset_prot <= m[1];
      active_sel_write <= m[2];
      cfg_write <= m[3];
      blocked_offset <= bo;
      active_sel_offset <= ao;
      @(posedge aclk);
      {cfg_write, active_sel_write, soft_reset_prot, blocked_write} <= 4'h0;
      @(posedge aclk);
      #1;
   endtask : ev

   initial begin
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      rd(spsc_pkg::STATUS_OFS, 32'h0, spsc_pkg::RESP_OKAY, d);
      rd(spsc_pkg::CAPS_OFS, 32'h001F_0154, spsc_pkg::RESP_OKAY, d);
      check(32'(d[20:16]), 32'h1F, "cap flags");
      check(32'({d[8], d[6], d[4]}), 32'h7, "cap adjust");
      check(32'(d[3:0]), 32'(spsc_pkg::NUM_SELECTS), "sel count");
      for (int k = 0; k < 2; k++) begin
         rd(spsc_pkg::REV_OFS, {20'h0, spsc_pkg::REV_NUMBER},
            spsc_pkg::RESP_OKAY, d);
         rd(spsc_pkg::CAPS_OFS, 32'h001F_0154, spsc_pkg::RESP_OKAY,
            d);
         wr(spsc_pkg::CAPS_OFS, spsc_pkg::RESP_OKAY);
         wr(spsc_pkg::REV_OFS, spsc_pkg::RESP_OKAY);
      end
      rd(8'h40, 32'h0, spsc_pkg::RESP_SLVERR, d);
      wr(8'h40, spsc_pkg::RESP_SLVERR);
      for (int c = 1; c < 8; c++) begin
         ev({1'b0, 3'(c)}, 8'h30, 8'h04);
         src = c[0] ? 8'h30 : (c[2] ? 8'h04 : 8'h00);
         check(32'(violation_status_code), 32'(c), "live code");
         rd(spsc_pkg::STATUS_OFS, {16'h0, src, 5'h00, 3'(c)},
            spsc_pkg::RESP_OKAY, d);
         #1;
         check(32'(violation_status_code), 32'h0, "live clear");
         rd(spsc_pkg::STATUS_OFS, 32'h0, spsc_pkg::RESP_OKAY, d);
      end
      ev(4'b0010, 8'h00, 8'h00);
      ev(4'b1000, 8'h00, 8'h00);
      rd(spsc_pkg::STATUS_OFS, 32'h0, spsc_pkg::RESP_OKAY, d);
      ev(4'b1010, 8'h00, 8'h00);
      rd(spsc_pkg::STATUS_OFS, 32'h2, spsc_pkg::RESP_OKAY, d);
      // Events while the clock enable is low are lost
      @(posedge aclk);
      aclken <= 1'b0;
      ev(4'b0101, 8'h30, 8'h04);
      check(32'(violation_status_code), 32'h0, "frozen code");
      @(posedge aclk);
      aclken <= 1'b1;
      rd(spsc_pkg::STATUS_OFS, 32'h0, spsc_pkg::RESP_OKAY, d);
      // Reset in mid-run clears recorded violations
      ev(4'b0101, 8'h30, 8'h04);
      @(posedge aclk);
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      #1;
      check(32'(violation_status_code), 32'h0, "reset code");
      rd(spsc_pkg::STATUS_OFS, 32'h0, spsc_pkg::RESP_OKAY, d);
      results();
   end

   initial begin
      repeat (3000) @(posedge aclk);
      n_mismatch++;
      results();
   end
endmodule : testbench

// File: verilog/spsc_regs.sv
// Operation
// - Status bit 0 set when protection blocked a configuration write.
// - Status bit 1 set on soft reset with protection; cleared by configuration writes.
// - Status bit 2 set on mode or select write while select active.
// - Simultaneous conditions report as the sum of their codes.
// - Reading the status clears accumulated violation indications.
// - Source field holds bus offset of the offending register.
// - Capability register at 0xF8 reads 0x001F0154.
// - Capability flags: spurious guard, rx queue, release, decoder.
// - Capability flag shows bridge kind.
// - Capability shows length adjustable, else fixed length field.
// - Capability shows phase adjustable, else phase-is-zero flag.
// - Capability shows polarity adjustable, else positive flag.
// - Capability field gives number of select lines.
// - Revision register at 0xFC: 12-bit number plus reserved field.
// - Bus interface runs on one module clock.
// - Source in bits 15..8 of status at 0xE8, resets to zero.
//
// Decided for this implementation: the AXI4-Lite register port.
module spsc_regs (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic        aclken,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic        blocked_write,
   input  wire logic [7:0]  blocked_offset,
   input  wire logic        soft_reset_prot,
   input  wire logic        cfg_write,
   input  wire logic        active_sel_write,
   input  wire logic [7:0]  active_sel_offset,
   output logic [2:0]       violation_status_code
);
   logic        aw_held;
   logic        w_held;
   logic [7:0]  aw_addr;
   logic        status_read;
   logic [2:0]  code;
   logic [7:0]  source;
   logic [31:0] rd_word;
   logic        rd_hit;
   logic        wr_hit;
   logic        caps_read;
   logic [31:0] caps_word;
   logic        spurious_guard_present;
   logic        rx_queue_present;
   logic        bridge_kind_flag;
   logic        select_release_feature_present;
   logic        external_select_decoder_present;
   logic [6:0]  fixed_char_length;
   logic        char_length_adjustable;
   logic        fixed_phase_is_zero;
   logic        phase_adjustable;
   logic        fixed_polarity_positive;
   logic        polarity_adjustable;
   logic [3:0]  select_line_count;

   // Single module clock for the whole bus side
   assign status_read = aclken && s_axi_arvalid && s_axi_arready
                        && s_axi_araddr == spsc_pkg::STATUS_OFS;

   spsc_viol_track u_track (
      .aclk              (aclk),
      .aresetn           (aresetn),
      .aclken            (aclken),
      .blocked_write     (blocked_write),
      .blocked_offset    (blocked_offset),
      .soft_reset_prot   (soft_reset_prot),
      .cfg_write         (cfg_write),
      .active_sel_write  (active_sel_write),
      .active_sel_offset (active_sel_offset),
      .status_read       (status_read),
      .code              (code),
      .source            (source)
   );

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         violation_status_code <= 3'h0;
      end else if (aclken) begin
         violation_status_code <= code;
      end
   end

   assign caps_read = aclken && s_axi_arvalid && s_axi_arready
                      && s_axi_araddr == spsc_pkg::CAPS_OFS;

   // Capability fields, fixed for this instance
   assign spurious_guard_present =
      spsc_pkg::CAPS_VALUE[spsc_pkg::SPURIOUS_GUARD_POS];
   assign rx_queue_present =
      spsc_pkg::CAPS_VALUE[spsc_pkg::RX_QUEUE_POS];
   assign bridge_kind_flag =
      spsc_pkg::CAPS_VALUE[spsc_pkg::BRIDGE_KIND_POS];
   assign select_release_feature_present =
      spsc_pkg::CAPS_VALUE[spsc_pkg::SELECT_RELEASE_POS];
   assign external_select_decoder_present =
      spsc_pkg::CAPS_VALUE[spsc_pkg::EXT_DECODER_POS];
   assign fixed_char_length =
      spsc_pkg::CAPS_VALUE[spsc_pkg::FIXED_LEN_LSB +: 7];
   assign char_length_adjustable =
      spsc_pkg::CAPS_VALUE[spsc_pkg::LEN_ADJ_POS];
   assign fixed_phase_is_zero =
      spsc_pkg::CAPS_VALUE[spsc_pkg::PHASE_ZERO_POS];
   assign phase_adjustable =
      spsc_pkg::CAPS_VALUE[spsc_pkg::PHASE_ADJ_POS];
   assign fixed_polarity_positive =
      spsc_pkg::CAPS_VALUE[spsc_pkg::POL_POS_POS];
   assign polarity_adjustable =
      spsc_pkg::CAPS_VALUE[spsc_pkg::POL_ADJ_POS];
   assign select_line_count =
      spsc_pkg::CAPS_VALUE[spsc_pkg::SEL_COUNT_LSB +: 4];

   // Capability word assembled from its fields
   always_comb begin
      caps_word = 32'h0000_0000;
      caps_word[spsc_pkg::SPURIOUS_GUARD_POS] = spurious_guard_present;
      caps_word[spsc_pkg::RX_QUEUE_POS] = rx_queue_present;
      caps_word[spsc_pkg::BRIDGE_KIND_POS] = bridge_kind_flag;
      caps_word[spsc_pkg::SELECT_RELEASE_POS] = select_release_feature_present;
      caps_word[spsc_pkg::EXT_DECODER_POS] = external_select_decoder_present;
      caps_word[spsc_pkg::FIXED_LEN_LSB +: 7] = fixed_char_length;
      caps_word[spsc_pkg::LEN_ADJ_POS] = char_length_adjustable;
      caps_word[spsc_pkg::PHASE_ZERO_POS] = fixed_phase_is_zero;
      caps_word[spsc_pkg::PHASE_ADJ_POS] = phase_adjustable;
      caps_word[spsc_pkg::POL_POS_POS] = fixed_polarity_positive;
      caps_word[spsc_pkg::POL_ADJ_POS] = polarity_adjustable;
      caps_word[spsc_pkg::SEL_COUNT_LSB +: 4] = select_line_count;
   end

   // Read decode
   always_comb begin
      rd_word = 32'h0000_0000;
      rd_hit  = 1'b1;
      case (s_axi_araddr)
         spsc_pkg::STATUS_OFS: begin
            rd_word[spsc_pkg::SRC_LSB +: 8]  = source;
            rd_word[spsc_pkg::CODE_LSB +: 3] = code;
         end
         spsc_pkg::CAPS_OFS: begin
            rd_word = caps_word;
         end
         spsc_pkg::REV_OFS: begin
            rd_word[11:0]  = spsc_pkg::REV_NUMBER;
            rd_word[19:16] = spsc_pkg::REV_RSVD;
         end
         default: begin
            rd_hit = 1'b0;
         end
      endcase
   end

   // Read channel
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= spsc_pkg::RESP_OKAY;
      end else if (aclken) begin
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_word;
            s_axi_rresp   <= rd_hit ? spsc_pkg::RESP_OKAY
                                    : spsc_pkg::RESP_SLVERR;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end
   end

   // Write channel; all mapped registers are read-only
   assign wr_hit = aw_addr == spsc_pkg::STATUS_OFS
                   || aw_addr == spsc_pkg::CAPS_OFS
                   || aw_addr == spsc_pkg::REV_OFS;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held       <= 1'b0;
         w_held        <= 1'b0;
         aw_addr       <= 8'h00;
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= spsc_pkg::RESP_OKAY;
      end else if (aclken) begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held       <= 1'b1;
            aw_addr       <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held       <= 1'b1;
            s_axi_wready <= 1'b0;
         end
         if (aw_held && w_held && !s_axi_bvalid) begin
            // Data discarded, contents unchanged
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? spsc_pkg::RESP_OKAY
                                   : spsc_pkg::RESP_SLVERR;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid  <= 1'b0;
            aw_held       <= 1'b0;
            w_held        <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
      end
   end

   // Assertions
   property p_blocked_sets;
      @(posedge aclk) disable iff (!aresetn)
         aclken && blocked_write |=> code[0];
   endproperty
   a_blocked_sets: assert property (p_blocked_sets)
      else $error("blocked write not flagged");

   property p_reset_sets;
      @(posedge aclk) disable iff (!aresetn)
         aclken && soft_reset_prot |=> code[1];
   endproperty
   a_reset_sets: assert property (p_reset_sets)
      else $error("soft reset not flagged");

   property p_cfg_clears;
      @(posedge aclk) disable iff (!aresetn)
         aclken && cfg_write && !soft_reset_prot |=> !code[1];
   endproperty
   a_cfg_clears: assert property (p_cfg_clears)
      else $error("config write did not clear reset flag");

   property p_active_sets;
      @(posedge aclk) disable iff (!aresetn)
         aclken && active_sel_write |=> code[2];
   endproperty
   a_active_sets: assert property (p_active_sets)
      else $error("active select write not flagged");

   property p_read_clears;
      @(posedge aclk) disable iff (!aresetn)
         status_read && !blocked_write && !soft_reset_prot
         && !active_sel_write |=> code == 3'h0;
   endproperty
   a_read_clears: assert property (p_read_clears)
      else $error("status read did not clear");

   property p_status_data;
      @(posedge aclk) disable iff (!aresetn)
         status_read |=> s_axi_rvalid
         && s_axi_rdata[2:0] == $past(code)
         && s_axi_rdata[15:8] == $past(source);
   endproperty
   a_status_data: assert property (p_status_data)
      else $error("status read data wrong");

   property p_source;
      @(posedge aclk) disable iff (!aresetn)
         aclken && blocked_write |=> source == $past(blocked_offset);
   endproperty
   a_source: assert property (p_source)
      else $error("source offset wrong");

   property p_caps;
      @(posedge aclk) disable iff (!aresetn)
         aclken && s_axi_arvalid && s_axi_arready
         && s_axi_araddr == spsc_pkg::CAPS_OFS
         |=> s_axi_rdata == 32'h001F_0154;
   endproperty
   a_caps: assert property (p_caps)
      else $error("capability value wrong");

   property p_caps_guard;
      @(posedge aclk) disable iff (!aresetn)
         caps_read |=> s_axi_rdata[20:19] == 2'h3 && s_axi_rdata[17:16] == 2'h3;
   endproperty
   a_caps_guard: assert property (p_caps_guard)
      else $error("capability feature flags wrong");

   property p_caps_bridge;
      @(posedge aclk) disable iff (!aresetn)
         caps_read |=> s_axi_rdata[18] == 1'b1;
   endproperty
   a_caps_bridge: assert property (p_caps_bridge)
      else $error("capability bridge flag wrong");

   property p_caps_len;
      @(posedge aclk) disable iff (!aresetn)
         caps_read |=> s_axi_rdata[8] && s_axi_rdata[15:9] == 7'h00;
   endproperty
   a_caps_len: assert property (p_caps_len)
      else $error("capability length fields wrong");

   property p_caps_phase;
      @(posedge aclk) disable iff (!aresetn)
         caps_read |=> s_axi_rdata[6] && !s_axi_rdata[7];
   endproperty
   a_caps_phase: assert property (p_caps_phase)
      else $error("capability phase fields wrong");

   property p_caps_pol;
      @(posedge aclk) disable iff (!aresetn)
         caps_read |=> s_axi_rdata[4] && !s_axi_rdata[5];
   endproperty
   a_caps_pol: assert property (p_caps_pol)
      else $error("capability polarity fields wrong");

   property p_caps_count;
      @(posedge aclk) disable iff (!aresetn)
         caps_read |=> s_axi_rdata[3:0] == 4'h4;
   endproperty
   a_caps_count: assert property (p_caps_count)
      else $error("capability select count wrong");

   property p_rev;
      @(posedge aclk) disable iff (!aresetn)
         aclken && s_axi_arvalid && s_axi_arready
         && s_axi_araddr == spsc_pkg::REV_OFS
         |=> s_axi_rdata[31:12] == 20'h00000;
   endproperty
   a_rev: assert property (p_rev)
      else $error("revision upper bits not zero");

   property p_bresp_time;
      @(posedge aclk) disable iff (!aresetn)
         aclken && aw_held && w_held && !s_axi_bvalid |=> s_axi_bvalid;
   endproperty
   a_bresp_time: assert property (p_bresp_time)
      else $error("write response late");

   property p_freeze;
      @(posedge aclk) disable iff (!aresetn)
         !aclken |=> $stable(code) && $stable(source)
         && $stable(s_axi_rvalid) && $stable(s_axi_bvalid);
   endproperty
   a_freeze: assert property (p_freeze)
      else $error("state moved while clock enable low");

   c_read_status: cover property (@(posedge aclk) status_read);
   c_all_three: cover property (@(posedge aclk) code == 3'h7);
   c_write_done: cover property (@(posedge aclk)
      s_axi_bvalid && s_axi_bready);
endmodule : spsc_regs

// File: verilog/spsc_viol_track.sv
module spsc_viol_track (
   input  wire logic       aclk,
   input  wire logic       aresetn,
   input  wire logic       aclken,
   input  wire logic       blocked_write,
   input  wire logic [7:0] blocked_offset,
   input  wire logic       soft_reset_prot,
   input  wire logic       cfg_write,
   input  wire logic       active_sel_write,
   input  wire logic [7:0] active_sel_offset,
   input  wire logic       status_read,
   output logic      [2:0] code,
   output logic      [7:0] source
);
   logic [2:0] next_code;

   // Set wins over read-clear
   always_comb begin
      next_code = status_read ? 3'h0 : code;
      if (cfg_write && !soft_reset_prot) begin
         next_code[1] = 1'b0;
      end
      if (blocked_write) begin
         next_code[0] = 1'b1;
      end
      if (soft_reset_prot) begin
         next_code[1] = 1'b1;
      end
      if (active_sel_write) begin
         next_code[2] = 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         code <= 3'h0;
      end else if (aclken) begin
         code <= next_code;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         source <= 8'h00;
      end else if (aclken) begin
         if (blocked_write) begin
            source <= blocked_offset;
         end else if (active_sel_write) begin
            source <= active_sel_offset;
         end else if (status_read) begin
            source <= 8'h00;
         end
      end
   end
endmodule : spsc_viol_track
